/* src/sadc_defs.svh */
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

// ****************************************
// timing
// ****************************************
`define SADC_CLK_PERIOD_PS   25000
`define SADC_CONV_PULSE_NS   40
`define SADC_CONV_PULSE_CYC  ((`SADC_CONV_PULSE_NS * 1000 + `SADC_CLK_PERIOD_PS - 1) / `SADC_CLK_PERIOD_PS)
`define SADC_SETUP_NS        10
`define SADC_SETUP_CYC       (((`SADC_SETUP_NS * 1000 + `SADC_CLK_PERIOD_PS - 1) / `SADC_CLK_PERIOD_PS) > 0 ? \
                              ((`SADC_SETUP_NS * 1000 + `SADC_CLK_PERIOD_PS - 1) / `SADC_CLK_PERIOD_PS) : 1)
`define SADC_SPACING_US      10
`define SADC_SPACING_CYC     ((`SADC_SPACING_US * 1000000 + `SADC_CLK_PERIOD_PS - 1) / `SADC_CLK_PERIOD_PS)
`define SADC_CONV_US         8
`define SADC_CONV_CYC        ((`SADC_CONV_US * 1000000) / `SADC_CLK_PERIOD_PS)
`define SADC_EARLY_US        7
`define SADC_EARLY_CYC       ((`SADC_EARLY_US * 1000000) / `SADC_CLK_PERIOD_PS)
// ****************************************
// reset values
// ****************************************
`define SADC_RESULT_RST      16'h0000
`define SADC_BUSY_RST        1'b0
`define SADC_OE_RST          1'b0
`define SADC_START_Q_RST     1'b1
`endif

/* src/sadc_pkg.sv */
package sadc_pkg;
   typedef logic [15:0] sadc_word_t;
   typedef logic [7:0]  sadc_byte_t;
   typedef enum logic [2:0] {SADC_H_IDLE, SADC_H_SETUP, SADC_H_PULSE, SADC_H_WAIT,
                             SADC_H_READ, SADC_H_GAP} sadc_host_st_t;
endpackage

/* src/sadc_if.sv */
`timescale 1ns/1ps
interface sadc_if;
   logic                 cs_n;
   logic                 rd_conv;
   logic                 byte_sel;
   logic                 busy_n;
   sadc_pkg::sadc_word_t result_data;
   logic                 data_oe;
   modport dev  (input cs_n, rd_conv, byte_sel, output busy_n, result_data, data_oe);
   modport host (output cs_n, rd_conv, byte_sel, input busy_n, result_data, data_oe);
endinterface

/* src/sadc_dev.sv */
`timescale 1ns/1ps
`include "sadc_defs.svh"
module sadc_dev #(
   parameter int CONV_CYC = `SADC_CONV_CYC
) (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // host link
   sadc_if.dev                       link,
   // converter core
   input  wire sadc_pkg::sadc_word_t sample_i,
   output logic                      hold_o,
   output logic                      byte_mode_i_unused_o
);
   // ****************************************
   // local sizes
   // ****************************************
   // the counter only has to reach the last cycle of a conversion
   localparam int CNT_W = (CONV_CYC > 1) ? $clog2(CONV_CYC) : 1;
   // width of one byte lane
   localparam int HALF  = 8;
   // limitations: the select and convert lines are sampled on the clock, so a
   // convert pulse must span at least one rising edge to be seen; a read in
   // the middle of a conversion shows the previous word for the whole
   // conversion, which is more lenient than a host may rely on

   // ****************************************
   // declarations
   // ****************************************
   // request level and its edge
   logic                 start_lvl;
   logic                 start_lvl_q;
   logic                 next_start_lvl_q;
   logic                 req_edge;
   logic                 restart;
   logic                 start;
   // conversion progress
   logic                 busy;
   logic                 next_busy;
   logic                 ended;
   logic                 next_ended;
   logic                 last_cyc;
   logic [CNT_W-1:0]     cnt;
   logic [CNT_W-1:0]     next_cnt;
   // stored result
   sadc_pkg::sadc_word_t result;
   sadc_pkg::sadc_word_t next_result;
   // bus enable and lanes
   logic                 oe;
   logic                 next_oe;
   sadc_pkg::sadc_word_t lane;
   sadc_pkg::sadc_word_t next_lane;

   // ****************************************
   // start detection
   // ****************************************
   // the two lines are ORed and edge triggered, so either may fall first
   assign start_lvl = ~(link.cs_n | link.rd_conv);
   assign req_edge  = start_lvl & ~start_lvl_q;
   // a request still low on the edge after busy cleared starts again at once:
   // that conversion had no acquisition time, so its result is not valid
   assign restart   = start_lvl & ended;
   // requests while converting are dropped, not queued
   assign start     = (req_edge | restart) & ~busy;

   always_comb begin
      next_start_lvl_q = start_lvl;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // seen as already low, so a request held through reset starts nothing
         start_lvl_q <= `SADC_START_Q_RST;
      end else begin
         start_lvl_q <= next_start_lvl_q;
      end
   end

   // ****************************************
   // busy
   // ****************************************
   // busy is a register, so the host never sees a glitch on it
   assign last_cyc = (cnt == CNT_W'(CONV_CYC - 1));

   always_comb begin
      next_busy = busy;
      if (start) begin
         // the sample stage goes to hold on this very edge
         next_busy = 1'b1;
      end else if (busy && last_cyc) begin
         next_busy = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy <= `SADC_BUSY_RST;
      end else begin
         busy <= next_busy;
      end
   end

   // ****************************************
   // conversion count
   // ****************************************
   // no clock enable: while busy the count steps on every edge of the one clock but the last, where it holds
   always_comb begin
      next_cnt = cnt;
      if (start) begin
         next_cnt = '0;
      end else if (busy && !last_cyc) begin
         next_cnt = cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   // ****************************************
   // end of conversion
   // ****************************************
   // one-cycle mark of the edge on which busy cleared
   always_comb begin
      next_ended = busy & last_cyc;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ended <= 1'b0;
      end else begin
         ended <= next_ended;
      end
   end

   // ****************************************
   // result store
   // ****************************************
   // busy clears on the same edge, so a host latching on busy rising sees the new word
   always_comb begin
      next_result = result;
      if (busy && last_cyc) begin
         next_result = sample_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result <= `SADC_RESULT_RST;
      end else begin
         result <= next_result;
      end
   end

   // ****************************************
   // bus enable
   // ****************************************
   // the enable follows the pins one cycle late; a host must wait for it
   // before it takes the bus
   always_comb begin
      next_oe = ~link.cs_n & link.rd_conv;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         oe <= `SADC_OE_RST;
      end else begin
         oe <= next_oe;
      end
   end

   // ****************************************
   // byte lanes
   // ****************************************
   // byte low swaps the halves so the narrow lane carries the upper byte;
   // the lanes are built from the next result so they never lag a new word
   for (genvar b = 0; b < HALF; b++) begin : g_lane
      assign next_lane[b]        = link.byte_sel ? next_result[b] : next_result[b + HALF];
      assign next_lane[b + HALF] = link.byte_sel ? next_result[b + HALF] : next_result[b];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lane <= `SADC_RESULT_RST;
      end else begin
         lane <= next_lane;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign link.busy_n      = ~busy;
   assign link.data_oe     = oe;
   assign link.result_data = lane;
   assign hold_o           = busy;
   // the bus is always sixteen wide here, so no separate byte mode is reported
   assign byte_mode_i_unused_o = 1'b0;
endmodule

/* src/sadc_host.sv */
`timescale 1ns/1ps
`include "sadc_defs.svh"
module sadc_host (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // user side
   input  wire logic                 req_i,
   output logic                      ready_o,
   output sadc_pkg::sadc_word_t      data_o,
   output logic                      valid_o,
   // link
   sadc_if.host                      link
);
   sadc_pkg::sadc_host_st_t st, next_st;
   logic [31:0]          tmr, next_tmr;
   logic                 busy_q, next_busy_q;
   sadc_pkg::sadc_word_t data, next_data;
   logic                 valid, next_valid;
   logic [1:0]           rd_step, next_rd_step;

   always_comb begin
      next_st     = st;
      next_tmr    = (tmr != 32'd0) ? tmr - 32'd1 : 32'd0;
      next_busy_q = link.busy_n;
      next_data   = data;
      next_valid  = 1'b0;
      next_rd_step = rd_step;
      unique case (st)
         sadc_pkg::SADC_H_IDLE: begin
            if (req_i && link.busy_n) begin
               next_st  = sadc_pkg::SADC_H_SETUP;
               next_tmr = 32'(`SADC_SETUP_CYC);
            end
         end
         sadc_pkg::SADC_H_SETUP: begin
            if (tmr == 32'd0) begin
               next_st  = sadc_pkg::SADC_H_PULSE;
               next_tmr = 32'(`SADC_CONV_PULSE_CYC);
            end
         end
         sadc_pkg::SADC_H_PULSE: begin
            // release before busy can return high
            if (tmr == 32'd0) begin
               next_st = sadc_pkg::SADC_H_WAIT;
            end
         end
         sadc_pkg::SADC_H_WAIT: begin
            // read only after busy rises, never late in the conversion
            if (link.busy_n && !busy_q) begin
               next_st = sadc_pkg::SADC_H_READ;
            end
         end
         sadc_pkg::SADC_H_READ: begin
            // the bus enable is registered: take nothing before it stands
            if (rd_step == 2'h0) begin
               if (link.data_oe) begin
                  next_data[15:8] = link.result_data[7:0];
                  next_rd_step    = 2'h1;
               end
            end else if (rd_step == 2'h1) begin
               // the lane switch shows one cycle later on the registered bus
               next_rd_step = 2'h2;
            end else begin
               next_data[7:0] = link.result_data[7:0];
               next_rd_step   = 2'h0;
               next_valid     = 1'b1;
               next_st        = sadc_pkg::SADC_H_GAP;
               next_tmr       = 32'(`SADC_SPACING_CYC);
            end
         end
         sadc_pkg::SADC_H_GAP: begin
            if (tmr == 32'd0) begin
               next_st = sadc_pkg::SADC_H_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st     <= sadc_pkg::SADC_H_IDLE;
         tmr    <= '0;
         busy_q <= 1'b1;
         data   <= '0;
         valid  <= 1'b0;
         rd_step <= 2'h0;
      end else begin
         st     <= next_st;
         tmr    <= next_tmr;
         busy_q <= next_busy_q;
         data   <= next_data;
         valid  <= next_valid;
         rd_step <= next_rd_step;
      end
   end

   assign link.rd_conv  = ~(st == sadc_pkg::SADC_H_SETUP || st == sadc_pkg::SADC_H_PULSE);
   assign link.cs_n     = ~(st == sadc_pkg::SADC_H_PULSE || st == sadc_pkg::SADC_H_READ);
   // byte-wide read: upper byte first, then lower byte
   assign link.byte_sel = (rd_step != 2'h0);
   assign ready_o       = (st == sadc_pkg::SADC_H_IDLE);
   assign data_o        = data;
   assign valid_o       = valid;
endmodule

/* dv/sadc_link_properties.sv */
`timescale 1ns/1ps
module sadc_link_properties #(
   parameter int CONV_CYC = 320
) (
   // clock and reset
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   // link
   input wire logic                 cs_n,
   input wire logic                 rd_conv,
   input wire logic                 byte_sel,
   input wire logic                 busy_n,
   input wire sadc_pkg::sadc_word_t result_data,
   input wire logic                 data_oe
);
   // ********
   // busy length
   // ********
   int busy_cnt;
   int next_busy_cnt;
   always_comb begin
      next_busy_cnt = busy_n ? 0 : busy_cnt + 1;
   end
   always_ff @(posedge clk_i) begin
      busy_cnt <= rst_i ? 0 : next_busy_cnt;
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ********
   // properties
   // ********
   chk_oe_off_idle: assert property ((cs_n || !rd_conv) |=> !data_oe)
      else $error("data bus enabled without a read");
   chk_oe_on_read: assert property ((!cs_n && rd_conv) |=> data_oe)
      else $error("data bus not enabled for a read");
   chk_idle_no_start: assert property (cs_n |=> !$fell(busy_n))
      else $error("conversion started while deselected");
   chk_start_edge: assert property (busy_n && !(cs_n || rd_conv) && $past(cs_n || rd_conv) |=> $fell(busy_n))
      else $error("convert request not taken");
   chk_busy_bound: assert property (!busy_n |-> busy_cnt < CONV_CYC)
      else $error("conversion ran too long");
   chk_busy_length: assert property ($rose(busy_n) |-> busy_cnt == CONV_CYC)
      else $error("busy ended early");
   chk_start_hiz: assert property (!rd_conv && $fell(cs_n) |-> !data_oe ##1 !data_oe)
      else $error("data bus driven at conversion start");
   // result only moves when a conversion ends or the byte selector moves
   chk_result_steady: assert property (!$past(rst_i) && !$rose(busy_n) && $stable(byte_sel)
      && $past(byte_sel, 2) == byte_sel |-> $stable(result_data))
      else $error("result changed without a new conversion");
endmodule

/* dv/sar_adc_convert_read_control_tb_top.sv */
`timescale 1ns/1ps
module sar_adc_convert_read_control_tb_top;
   // ********
   // harness
   // ********
   localparam int        CONV = 8;
   logic                 clk_i = 1'b0;
   logic                 rst_i = 1'b1;
   logic                 req_i = 1'b0;
   logic                 ready_o;
   logic                 valid_o;
   logic                 hold_o;
   sadc_pkg::sadc_word_t sample_i = 16'h0000;
   sadc_pkg::sadc_word_t last = 16'h0000;
   logic                 sel_q = 1'b0;
   sadc_pkg::sadc_word_t data_o;
   int                   errors = 0;
   int                   n_compared = 0;
   // sample driven, word expected at the host
   sadc_pkg::sadc_word_t rows [5][2] = '{'{16'h7fff, 16'h7fff}, '{16'h8000, 16'h8000}, '{16'hffff, 16'hffff},
                                         '{16'h0000, 16'h0000}, '{16'h12c4, 16'h12c4}};
   sadc_if link ();
   always #12.5 clk_i = ~clk_i;
   sadc_dev #(.CONV_CYC(CONV)) sadc_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link), .sample_i(sample_i),
      .hold_o(hold_o), .byte_mode_i_unused_o());
   sadc_host sadc_host_inst (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .ready_o(ready_o), .data_o(data_o),
      .valid_o(valid_o), .link(link));
   sadc_link_properties #(.CONV_CYC(CONV)) sadc_link_properties_inst (.clk_i(clk_i), .rst_i(rst_i),
      .cs_n(link.cs_n), .rd_conv(link.rd_conv), .byte_sel(link.byte_sel), .busy_n(link.busy_n),
      .result_data(link.result_data), .data_oe(link.data_oe));
   // ********
   // tasks
   // ********
   task automatic check(input string what, input sadc_pkg::sadc_word_t exp, input sadc_pkg::sadc_word_t got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_bit(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic stop_test;
      if (errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic reset_check;
      check_bit("busy_n", 1'b1, link.busy_n);
      check_bit("data_oe", 1'b0, link.data_oe);
   endtask
   task automatic xfer(input sadc_pkg::sadc_word_t s, input sadc_pkg::sadc_word_t e);
      int n;
      n = 0;
      while (ready_o !== 1'b1 && n < 2000) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 2000) errors++;
      sample_i = s;
      last = s;
      req_i = 1'b1;
      @(negedge clk_i);
      req_i = 1'b0;
      n = 0;
      while (valid_o !== 1'b1 && n < 2000) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 2000) errors++;
      check("data_o", e, data_o);
      @(negedge clk_i);
      check_bit("valid_o", 1'b0, valid_o);
   endtask
   // bus watcher: byte order follows the selector, hold tracks busy
   always @(negedge clk_i) begin
      if (rst_i === 1'b0) begin
         check_bit("hold_o", ~link.busy_n, hold_o);
         // the bus is registered, so it follows the selector as it stood a cycle ago
         if (link.data_oe === 1'b1 && link.busy_n === 1'b1)
            check("result_data", sel_q ? last : {last[7:0], last[15:8]}, link.result_data);
      end
      sel_q = link.byte_sel;
   end
   // ********
   // sequence
   // ********
   initial begin
      repeat (16) @(negedge clk_i);
      rst_i = 1'b0;
      reset_check();
      foreach (rows[i]) xfer(rows[i][0], rows[i][1]);
      // reset in mid conversion, then recover
      while (ready_o !== 1'b1) @(negedge clk_i);
      req_i = 1'b1;
      @(negedge clk_i);
      req_i = 1'b0;
      while (link.busy_n !== 1'b0) @(negedge clk_i);
      rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      reset_check();
      xfer(16'h00ff, 16'h00ff);
      stop_test();
   end
   // six transfers of roughly 420 cycles each plus one aborted conversion, with ample margin
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      stop_test();
   end
endmodule
